//--- verilog/ufc_top.sv
// Frame configuration and alternative line status of a serial port.
// Assumes an AHB-Lite master and shifters on the user-side ports.
// Functional notes
// [R1] Loop select detaches the receive pin, feeding transmitter output inward.
// [R2] Looped characters pass only while transmitter and receiver are enabled.
// [R3] Loop 0 normal; loop 1 source 0 internal; source 1 single-wire pin.
// [R4] Stop-in-wait set disables the port during wait mode.
// [R5] Length bit selects eight or nine data bits, one start, one stop.
// [R6] Wakeup bit selects idle-line or address-mark wakeup.
// [R7] Idle type bit starts idle counting after start or after stop.
// [R8] Parity enable generates and checks parity in the top data bit.
// [R9] Even parity sets bit for odd ones count; odd parity the reverse.
// [R10] Parity type zero means even, one means odd.
// [R11] Frame control at index 2 decoded only while alternate map is 0.
// [R12] Alternative status at index 0 decoded only while alternate map is 1.
// [R13] Active edge flag set on polarity-selected edge, cleared by writing one.
// [R14] Bit error value captures the sampled line on a mismatch.
// [R15] Bit error flag set on mismatch when enabled, write one clears.
// [R16] Break flag set on received break when enabled, write one clears.
// [R17] Bit error mode: off, tick 9, tick 13, reserved.
// [R18] Break detect enable turns break detection on or off.
// [R19] Alternate map bit selects which register bank is decoded.
`timescale 1ns/1ps
module ufc_top
	import ufc_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	// AHB-Lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic [31:0]              hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	// Serial pins
	input  wire logic                rxPin,
	input  wire logic                txFromShifter,
	output logic                     txPin,
	// Shifter side
	input  wire ufc_line_evt_t       lineEvt,
	input  wire logic                waitMode,
	input  wire logic [8:0]          txChar,
	output logic                     rxToShifter,
	output logic                     portEnable,
	output ufc_frame_cfg_t           frameCfg,
	output logic                     txParity,
	// Interrupt
	output logic                     irq
);
	logic [1:0]     rstPipe;
	logic           rstSync_n;
	logic           phValid;
	logic           phWrite;
	logic [2:0]     phIdx;
	logic [7:0]     frameCtrl;
	logic [7:0]     altCtrl1;
	logic [2:0]     altCtrl2;
	logic [3:0]     lineCtrl;
	logic [7:0]     mapCtrl;
	logic           flagEdge;
	logic           flagBerr;
	logic           flagBrk;
	logic           berrValue;
	logic           alternate_map_select;
	logic           rxSel;
	logic           edgeHit;
	logic           berrHit;
	logic           brkHit;
	logic           parityNow;
	logic           loopOn;
	logic [7:0]     wbyte;
	logic [31:0]    next_rdata;
	ufc_berr_mode_t berrMode;

	// Reset release through two flip-flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			rstPipe <= 2'b00;
		else
			rstPipe <= {rstPipe[0], 1'b1};
	end
	assign rstSync_n = rstPipe[1];

	// Decoded write on a data phase
	function automatic logic wr_at(input logic [2:0] idx);
		wr_at = phValid && phWrite && (phIdx == idx);
	endfunction

	assign alternate_map_select     = mapCtrl[UFC_MC_ALTERNATE_MAP_SELECT];
	assign berrMode = ufc_berr_mode_t'(altCtrl2[2:1]);
	assign wbyte    = hwdata[7:0];
	assign loopOn   = frameCtrl[UFC_FC_LOOP];

	// Address phase capture
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			phValid <= 1'b0;
			phWrite <= 1'b0;
			phIdx   <= 3'h0;
		end else if (hready) begin
			phValid <= hsel && htrans[1];
			phWrite <= hwrite;
			phIdx   <= haddr[4:2];
		end
	end

	// Zero wait state, always OKAY
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Banked control registers
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			frameCtrl <= UFC_RST_BYTE;
			altCtrl1  <= UFC_RST_BYTE;
			altCtrl2  <= 3'h0;
			lineCtrl  <= 4'h0;
			mapCtrl   <= UFC_RST_BYTE;
		end else begin
			if (!alternate_map_select && wr_at(UFC_IDX_FRAME_CTRL)) // [R11] [R19]
				frameCtrl <= wbyte;
			if (alternate_map_select && wr_at(UFC_IDX_ALT_CTRL1)) // [R19]
				altCtrl1 <= wbyte & 8'h83;
			if (alternate_map_select && wr_at(UFC_IDX_ALT_CTRL2)) // [R19]
				altCtrl2 <= wbyte[2:0];
			if (wr_at(UFC_IDX_LINE_CTRL))
				lineCtrl <= wbyte[3:0];
			if (wr_at(UFC_IDX_MAP_CTRL))
				mapCtrl <= wbyte & 8'h90;
		end
	end

	// Read mux on the address phase; data out one cycle later
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (haddr[4:2])
			UFC_IDX_ALT_STATUS: begin
				if (alternate_map_select) // [R12]
					next_rdata[7:0] = {flagEdge, 4'h0, berrValue,
						flagBerr, flagBrk};
			end
			UFC_IDX_ALT_CTRL1: begin
				if (alternate_map_select)
					next_rdata[7:0] = altCtrl1;
			end
			UFC_IDX_FRAME_CTRL: begin
				next_rdata[7:0] = alternate_map_select ? {5'h00, altCtrl2}
					: frameCtrl; // [R11]
			end
			UFC_IDX_LINE_CTRL: next_rdata[3:0] = lineCtrl;
			UFC_IDX_MAP_CTRL:  next_rdata[7:0] = mapCtrl;
			default:           next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data register
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n)
			hrdata <= 32'h0000_0000;
		else if (hready && hsel && htrans[1] && !hwrite)
			hrdata <= next_rdata;
	end

	// Receive source selection
	always_comb begin
		case ({loopOn, frameCtrl[UFC_FC_RECEIVER_SOURCE_SELECT]})
			2'b10:   rxSel = txFromShifter; // [R1] [R3]
			2'b11:   rxSel = txPin; // [R3]
			default: rxSel = rxPin; // [R3]
		endcase
	end

	// Loop path needs both transmitter and receiver
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			rxToShifter <= 1'b1;
			txPin       <= 1'b1;
		end else begin
			if (loopOn && !(lineCtrl[UFC_LC_TE] && lineCtrl[UFC_LC_RE]))
				rxToShifter <= 1'b1; // [R2]
			else
				rxToShifter <= rxSel;
			txPin <= txFromShifter;
		end
	end

	// Wait mode gating and frame format out
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			portEnable <= 1'b1;
			frameCfg   <= '0;
			txParity   <= 1'b0;
		end else begin
			portEnable <= !(waitMode && frameCtrl[UFC_FC_SWAI]); // [R4]
			frameCfg.nineBit       <= frameCtrl[UFC_FC_NINE]; // [R5]
			frameCfg.wakeAddr      <= frameCtrl[UFC_FC_WAKE]; // [R6]
			frameCfg.idleAfterStop <= frameCtrl[UFC_FC_ILT]; // [R7]
			frameCfg.parityEnable  <= frameCtrl[UFC_FC_PEN]; // [R8]
			frameCfg.parityOdd     <= frameCtrl[UFC_FC_PTYP]; // [R10]
			txParity <= frameCtrl[UFC_FC_PEN] & parityNow; // [R8] [R9]
		end
	end

	// Parity over the outgoing character
	ufc_parity uParity (
		.dataIn    (txChar),
		.nineBit   (frameCtrl[UFC_FC_NINE]),
		.parityOdd (frameCtrl[UFC_FC_PTYP]),
		.parityBit (parityNow)
	);

	// Active edge on the selected receive input
	ufc_sync_edge uEdge (
		.clk_sys    (clk_sys),
		.rstSync_n  (rstSync_n),
		.lineIn     (rxSel),
		.polarity   (mapCtrl[UFC_MC_RPOL]),
		.activeEdge (edgeHit)
	);

	// Bit error sample point per mode
	always_comb begin
		case (berrMode)
			UFC_BE_TICK9:  berrHit = lineEvt.tick == UFC_TICK_MID; // [R17]
			UFC_BE_TICK13: berrHit = lineEvt.tick == UFC_TICK_LATE; // [R17]
			default:       berrHit = 1'b0; // [R17]
		endcase
		berrHit = berrHit && lineEvt.txBitValid
			&& (rxSel != lineEvt.txBit); // [R15]
		brkHit = altCtrl2[0] && lineEvt.breakSeen; // [R18]
	end

	// Sticky flags, set wins over clear
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			flagEdge  <= 1'b0;
			flagBerr  <= 1'b0;
			flagBrk   <= 1'b0;
			berrValue <= 1'b0;
		end else begin
			if (edgeHit) // [R13]
				flagEdge <= 1'b1;
			else if (alternate_map_select && wr_at(UFC_IDX_ALT_STATUS) && wbyte[UFC_AS_EDGE])
				flagEdge <= 1'b0; // [R13]
			if (berrHit) // [R15]
				flagBerr <= 1'b1;
			else if (alternate_map_select && wr_at(UFC_IDX_ALT_STATUS) && wbyte[UFC_AS_BERR])
				flagBerr <= 1'b0; // [R15]
			if (brkHit) // [R16]
				flagBrk <= 1'b1;
			else if (alternate_map_select && wr_at(UFC_IDX_ALT_STATUS) && wbyte[UFC_AS_BRK])
				flagBrk <= 1'b0; // [R16]
			if (berrHit)
				berrValue <= rxSel; // [R14]
		end
	end

	// Masked interrupt output
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n)
			irq <= 1'b0;
		else
			irq <= (flagEdge & altCtrl1[UFC_AS_EDGE])
				| (flagBerr & altCtrl1[UFC_AS_BERR])
				| (flagBrk & altCtrl1[UFC_AS_BRK]);
	end

	// Edge flag follows a detected edge
	a_edge_flag_set: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		edgeHit |=> flagEdge) // [R13]
		else $error("edge flag not set");

	// Bit error captures line value
	a_berr_capture: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		berrHit |=> flagBerr && (berrValue == $past(rxSel))) // [R14]
		else $error("bit error capture wrong");

	// No bit errors when disabled
	a_berr_off: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		(berrMode == UFC_BE_OFF) |-> !berrHit) // [R17]
		else $error("bit error while disabled");

	// Break with enable sets the flag
	a_break_gate: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		(lineEvt.breakSeen && altCtrl2[0]) |=> flagBrk) // [R16]
		else $error("break flag missed");

	// No break flag raised while disabled
	a_break_off: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		(!altCtrl2[0] && !flagBrk) |=> !flagBrk || $past(lineEvt.breakSeen)
		&& $past(altCtrl2[0])) // [R18]
		else $error("break flag set while disabled");

	// Wait mode disables the port
	a_wait_stop: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		(waitMode && frameCtrl[UFC_FC_SWAI]) |=> !portEnable) // [R4]
		else $error("port not stopped in wait");

	// Internal loop feeds the receiver from the transmitter
	a_loop_route: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		(loopOn && !frameCtrl[UFC_FC_RECEIVER_SOURCE_SELECT] && lineCtrl[UFC_LC_TE]
		&& lineCtrl[UFC_LC_RE]) |=> rxToShifter == $past(txFromShifter)) // [R1]
		else $error("loop route wrong");

	// Loop idle with the transmitter disabled
	a_loop_enable: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		(loopOn && !lineCtrl[UFC_LC_TE]) |=> rxToShifter) // [R2]
		else $error("loop active without enables");

	// Frame control hidden in the alternate map
	a_map_hide: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		(alternate_map_select && wr_at(UFC_IDX_FRAME_CTRL)) |=> $stable(frameCtrl)) // [R11]
		else $error("frame control written in alternate map");

	// Parity bit follows type
	a_parity_type: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		frameCtrl[UFC_FC_PEN] |=> txParity == ($past(parityNow))) // [R9]
		else $error("parity bit wrong");
endmodule

//--- verilog/ufc_pkg.sv
// Package for the serial frame configuration and line status block.
// Assumes AHB-Lite register access with 32-bit words, one per register.
package ufc_pkg;

	// Register indices in the two banks (byte address = 4 * index)
	localparam logic [2:0] UFC_IDX_ALT_STATUS = 3'h0;
	localparam logic [2:0] UFC_IDX_FRAME_CTRL = 3'h2;
	localparam logic [2:0] UFC_IDX_ALT_CTRL1  = 3'h1;
	localparam logic [2:0] UFC_IDX_ALT_CTRL2  = 3'h2;
	localparam logic [2:0] UFC_IDX_LINE_CTRL  = 3'h3;
	localparam logic [2:0] UFC_IDX_MAP_CTRL   = 3'h5;

	// Frame control field positions
	localparam int UFC_FC_LOOP = 7;
	localparam int UFC_FC_SWAI = 6;
	localparam int UFC_FC_RECEIVER_SOURCE_SELECT = 5;
	localparam int UFC_FC_NINE = 4;
	localparam int UFC_FC_WAKE = 3;
	localparam int UFC_FC_ILT  = 2;
	localparam int UFC_FC_PEN  = 1;
	localparam int UFC_FC_PTYP = 0;

	// Alternative status field positions
	localparam int UFC_AS_EDGE = 7;
	localparam int UFC_AS_BERV = 2;
	localparam int UFC_AS_BERR = 1;
	localparam int UFC_AS_BRK  = 0;

	// Line control and map control fields
	localparam int UFC_LC_TE   = 3;
	localparam int UFC_LC_RE   = 2;
	localparam int UFC_MC_ALTERNATE_MAP_SELECT = 7;
	localparam int UFC_MC_RPOL = 4;

	// Reset values
	localparam logic [7:0] UFC_RST_BYTE = 8'h00;

	// Bit timing: 16 ticks per bit
	localparam logic [3:0] UFC_TICK_MID  = 4'h8;
	localparam logic [3:0] UFC_TICK_LATE = 4'hC;

	// Bit error mode encodings
	typedef enum logic [1:0] {
		UFC_BE_OFF  = 2'b00,
		UFC_BE_TICK9 = 2'b01,
		UFC_BE_TICK13 = 2'b10,
		UFC_BE_RSVD = 2'b11
	} ufc_berr_mode_t;

	// Frame configuration carried to the shifters
	typedef struct packed {
		logic nineBit;
		logic wakeAddr;
		logic idleAfterStop;
		logic parityEnable;
		logic parityOdd;
	} ufc_frame_cfg_t;

	// Line events from the shifters
	typedef struct packed {
		logic txBitValid;
		logic txBit;
		logic [3:0] tick;
		logic breakSeen;
	} ufc_line_evt_t;

endpackage

//--- verilog/ufc_sync_edge.sv
// Receive line edge detector with selectable active polarity.
// Assumes the input is already synchronous to clk_sys.
`timescale 1ns/1ps
module ufc_sync_edge
	import ufc_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstSync_n,
	// Line
	input  wire logic lineIn,
	input  wire logic polarity,
	// Result
	output logic      activeEdge
);
	logic lineLast;

	// Previous line level
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n)
			lineLast <= 1'b1;
		else
			lineLast <= lineIn;
	end

	// Falling edge for polarity 0, rising for polarity 1
	always_comb begin
		activeEdge = polarity ? (lineIn & ~lineLast) : (~lineIn & lineLast);
	end
endmodule

//--- verilog/ufc_parity.sv
// Parity generator for eight or nine bit characters.
// Assumes the character value is stable in the cycle it is used.
`timescale 1ns/1ps
module ufc_parity
	import ufc_pkg::*;
(
	// Data
	input  wire logic [8:0] dataIn,
	input  wire logic       nineBit,
	input  wire logic       parityOdd,
	// Result
	output logic            parityBit
);
	logic ones;

	// Parity over the data bits below the parity position
	always_comb begin
		ones = nineBit ? ^dataIn[7:0] : ^dataIn[6:0];
		parityBit = parityOdd ? ~ones : ones;
	end
endmodule

//--- bench/ufc_node.sv
// Remote serial node that drives the receive line of the port.
// Assumes the bench sets the wanted line level; idle level is high.
`timescale 1ns/1ps
module ufc_node (
	// Clock
	input  wire logic clk_sys,
	// Control from the bench
	input  wire logic lineLvl,
	// Line
	input  wire logic txPin,
	output logic      rxPin,
	// Transmit level as the node sees it
	output logic      txSeen
);
	// Line level changes one edge after the bench asks
	initial rxPin = 1'b1;
	always @(posedge clk_sys) begin
		rxPin <= lineLvl;
	end

	// Transmit line sampled by the node, one edge late
	always @(posedge clk_sys) begin
		txSeen <= txPin;
	end
endmodule

//--- bench/ufc_top_tb_top.sv
// Bench for the frame configuration and line status block.
// Assumes zero wait state AHB-Lite slave and a remote node on rxPin.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
	err_count++; $display("[ERR] %0t %h %h", $time, (a), (e)); end end
module ufc_top_tb_top;
	import ufc_pkg::*;
	logic           clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0;
	logic [31:0]    haddr = '0, hwdata = '0, hrdata;
	logic [1:0]     htrans = '0;
	logic [2:0]     hsize = 3'h2;
	logic           hreadyout, hresp, rxPin, txPin, txFromShifter = 1;
	logic           waitMode = 0, rxToShifter, portEnable, txParity, irq;
	logic           lineLvl = 1, rdPend = 0, txSeen;
	logic [8:0]     txChar = '0;
	ufc_line_evt_t  lineEvt = '0;
	ufc_frame_cfg_t frameCfg;
	logic [31:0]    expQ[$];
	logic [31:0]    seed = 32'hd20b_b092, v, expV;
	int             err_count = 0, total_checks = 0;

	// Clock at 50 MHz
	always #10 clk_sys = ~clk_sys;

	ufc_top ufc_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .rxPin(rxPin),
		.txFromShifter(txFromShifter), .txPin(txPin), .lineEvt(lineEvt),
		.waitMode(waitMode), .txChar(txChar), .rxToShifter(rxToShifter),
		.portEnable(portEnable), .frameCfg(frameCfg), .txParity(txParity),
		.irq(irq));
	ufc_node ufc_node_i (.clk_sys(clk_sys), .lineLvl(lineLvl),
		.txPin(txPin), .rxPin(rxPin), .txSeen(txSeen));

	// Read data check: oldest expectation against the data phase
	always @(posedge clk_sys) begin
		if (rdPend && hreadyout === 1'b1) begin
			expV = expQ.pop_front();
			`CHK(hrdata, expV)
			`CHK(hresp, 1'b0)
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// One single word transfer, waiting on hready in both phases
	task automatic bus(input logic wr, input logic [2:0] idx,
		input logic [31:0] d);
		@(posedge clk_sys);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr  <= {27'h0, idx, 2'b00};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rdPend <= !wr;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rdPend <= 1'b0;
	endtask

	task automatic wr(input logic [2:0] idx, input logic [7:0] d);
		bus(1'b1, idx, {24'h0, d});
	endtask

	task automatic rd(input logic [2:0] idx, input logic [7:0] e);
		expQ.push_back({24'h0, e});
		bus(1'b0, idx, 32'h0000_0000);
	endtask

	// One cycle pulse of a shifter line event
	task automatic pulse(input ufc_line_evt_t ev);
		@(posedge clk_sys);
		lineEvt <= ev;
		@(posedge clk_sys);
		lineEvt <= '0;
		cyc(2);
	endtask

	task automatic final_report();
		if (err_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		#200000;
		err_count++;
		final_report();
	end

	initial begin
		logic [7:0] md[3];
		logic [1:0] m;
		logic       hit;
		logic       bv;
		md = '{8'h00, 8'h80, 8'hA0};
		bv = 1'b0;
		cyc(4);
		rst_n <= 1'b1;
		cyc(3);
		// Reset state and random frame configuration
		rd(UFC_IDX_FRAME_CTRL, 8'h00);
		`CHK(frameCfg, 5'h00)
		v = $random(seed);
		wr(UFC_IDX_FRAME_CTRL, v[7:0]);
		rd(UFC_IDX_FRAME_CTRL, v[7:0]);
		`CHK(frameCfg, v[4:0])
		rd(3'h4, 8'h00);
		rd(UFC_IDX_ALT_STATUS, 8'h00);
		// Parity even and odd over eight and nine bit characters
		for (int k = 0; k < 8; k++) begin
			v = $random(seed);
			wr(UFC_IDX_FRAME_CTRL, {3'h0, k[1], 2'h0, 1'b1, k[0]});
			txChar <= {1'b0, v[7:0]};
			hit = (k[1] ? ^v[7:0] : ^v[6:0]) ^ k[0];
			cyc(3);
			`CHK(txParity, hit)
		end
		wr(UFC_IDX_FRAME_CTRL, 8'h00);
		cyc(3);
		`CHK(txParity, 1'b0)
		// Wait mode with stop-in-wait set and clear
		waitMode <= 1'b1;
		wr(UFC_IDX_FRAME_CTRL, 8'h40);
		cyc(3);
		`CHK(portEnable, 1'b0)
		wr(UFC_IDX_FRAME_CTRL, 8'h00);
		cyc(3);
		`CHK(portEnable, 1'b1)
		waitMode <= 1'b0;
		// Normal, loop and single-wire source: line high, transmitter low
		wr(UFC_IDX_LINE_CTRL, 8'h0C);
		txFromShifter <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			wr(UFC_IDX_FRAME_CTRL, md[i]);
			cyc(4);
			`CHK(rxToShifter, i == 0)
		end
		`CHK(txPin, 1'b0)
		`CHK(txSeen, 1'b0)
		// Loop with the receiver disabled passes nothing
		wr(UFC_IDX_LINE_CTRL, 8'h08);
		wr(UFC_IDX_FRAME_CTRL, 8'h80);
		cyc(4);
		`CHK(rxToShifter, 1'b1)
		wr(UFC_IDX_LINE_CTRL, 8'h0C);
		cyc(4);
		`CHK(rxToShifter, 1'b0)
		txFromShifter <= 1'b1;
		wr(UFC_IDX_FRAME_CTRL, 8'h00);
		// Alternate map: edge flag, mask and write-one clear
		wr(UFC_IDX_MAP_CTRL, 8'h80);
		rd(UFC_IDX_FRAME_CTRL, 8'h00);
		wr(UFC_IDX_ALT_STATUS, 8'h87);
		rd(UFC_IDX_ALT_STATUS, 8'h00);
		wr(UFC_IDX_ALT_CTRL1, 8'h80);
		lineLvl <= 1'b0;
		cyc(5);
		`CHK(irq, 1'b1)
		rd(UFC_IDX_ALT_STATUS, 8'h80);
		wr(UFC_IDX_ALT_STATUS, 8'h80);
		rd(UFC_IDX_ALT_STATUS, 8'h00);
		`CHK(irq, 1'b0)
		// Rising edge ignored at polarity 0, counted at polarity 1
		lineLvl <= 1'b1;
		cyc(5);
		rd(UFC_IDX_ALT_STATUS, 8'h00);
		wr(UFC_IDX_MAP_CTRL, 8'h90);
		lineLvl <= 1'b0;
		cyc(5);
		rd(UFC_IDX_ALT_STATUS, 8'h00);
		lineLvl <= 1'b1;
		cyc(5);
		rd(UFC_IDX_ALT_STATUS, 8'h80);
		wr(UFC_IDX_MAP_CTRL, 8'h80);
		wr(UFC_IDX_ALT_STATUS, 8'h87);
		// Bit error over every mode, reserved too, and both ticks
		wr(UFC_IDX_ALT_CTRL1, 8'h02);
		for (int i = 0; i < 8; i++) begin
			m = 2'(i / 2);
			hit = (m == 2'b01 && !i[0]) || (m == 2'b10 && i[0]);
			bv = hit ? 1'b1 : bv;
			wr(UFC_IDX_ALT_CTRL2, {5'h0, m, 1'b0});
			pulse('{txBitValid: 1'b1, txBit: 1'b0,
				tick: i[0] ? 4'hC : 4'h8, breakSeen: 1'b0});
			rd(UFC_IDX_ALT_STATUS,
				{5'h0, bv, hit, 1'b0});
			`CHK(irq, hit)
			wr(UFC_IDX_ALT_STATUS, 8'h87);
		end
		// Low line against a high bit captures a zero value
		lineLvl <= 1'b0;
		wr(UFC_IDX_ALT_CTRL2, 8'h02);
		pulse('{txBitValid: 1'b1, txBit: 1'b1, tick: 4'h8,
			breakSeen: 1'b0});
		rd(UFC_IDX_ALT_STATUS, 8'h82);
		lineLvl <= 1'b1;
		wr(UFC_IDX_ALT_STATUS, 8'h87);
		// Break with detection off and on
		wr(UFC_IDX_ALT_CTRL1, 8'h01);
		for (int e = 0; e < 2; e++) begin
			wr(UFC_IDX_ALT_CTRL2, {7'h0, e[0]});
			pulse('{txBitValid: 1'b0, txBit: 1'b0, tick: 4'h0,
				breakSeen: 1'b1});
			rd(UFC_IDX_ALT_STATUS, {7'h0, e[0]});
			`CHK(irq, e[0])
			wr(UFC_IDX_ALT_STATUS, 8'h01);
		end
		cyc(4);
		final_report();
	end
endmodule
